// ===== adc_pkg.sv
// Package for the axis drive command and error status block.
// Holds command codes, error bit positions, widths and the carrier types.
package adc_pkg;

    localparam int DATA_W = 32;
    localparam int CMD_W = 16;

    // Command codes written to the command write register.
    localparam logic [15:0] CMD_RESET = 16'h00FF;
    localparam logic [15:0] CMD_ERR_CLEAR = 16'h0079;
    localparam logic [15:0] CMD_REL_DRIVE = 16'h0050;
    localparam logic [15:0] CMD_CREL_DRIVE = 16'h0051;
    localparam logic [15:0] CMD_ABS_DRIVE = 16'h0054;
    localparam logic [15:0] CMD_STOP = 16'h0027;
    localparam logic [15:0] CMD_LIMIT_CFG = 16'h0020;

    // Error status bit positions.
    localparam int ERR_LIM_POS = 0;
    localparam int ERR_LIM_NEG = 1;
    localparam int ERR_ALARM = 2;
    localparam int ERR_ESTOP = 3;
    localparam int ERR_W = 4;

    // Limit enable field positions in the limit configuration data word.
    localparam int LIMCFG_POS_EN = 0;
    localparam int LIMCFG_NEG_EN = 1;
    localparam logic [1:0] LIMCFG_RESET = 2'h3;

    // Speed is a plain pulse rate; the phase accumulator is this wide.
    localparam int ACC_W = 32;

    typedef struct packed {
        logic valid;
        logic [15:0] code;
        logic [31:0] data;
    } adc_cmd_t;

    typedef struct packed {
        logic pos_limit;
        logic neg_limit;
        logic alarm;
        logic estop;
    } adc_fault_t;

endpackage

// ===== adc_axis_drive.sv
// Single axis pulse drive: command decode, fixed pulse drives and error status.
// Assumes commands arrive as one-cycle valid strikes synchronous to clk.
// Functional notes
// [RULE_01] The host holds external_reset_low low for more than 8 clock cycles with the clock running.
// [RULE_02] Writing 00FF to the command register resets the block as a hardware reset would.
// [RULE_03] Speed values are taken as real pulse rates with no range multiplier.
// [RULE_04] Relative drive outputs a positive count in plus, a negative count in minus.
// [RULE_05] Counter relative drive outputs a positive count in the minus direction.
// [RULE_06] Absolute drive runs until the logical position equals the given target.
// [RULE_07] An error source active during a drive sets its bit, which stays set afterward.
// [RULE_08] An error source already active when a drive starts sets its bit too.
// [RULE_09] An error source that turns on while idle is not recorded.
// [RULE_10] Command 79 or the start of the next drive clears all error bits.
// [RULE_11] After an interpolation error the host confirms stop before issuing 79.
// [RULE_12] Software may enable or disable each hardware limit input.
// [RULE_13] Every command write is decoded and executed on this axis; the code ignores drive commands and 79 written while a drive runs.
`timescale 1ns/1ps
module adc_axis_drive
    import adc_pkg::*;
#(
    parameter int CLK_HZ = 200_000_000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic external_reset_low,
    // Command write register
    input wire adc_pkg::adc_cmd_t cmd,
    input wire logic [31:0] speed_pps,
    // Fault inputs, active high
    input wire adc_pkg::adc_fault_t fault,
    // Motor pulse outputs
    output logic pulse_out,
    output logic dir_minus,
    output logic driving,
    // Status
    output logic [3:0] error_status_register,
    output logic [31:0] logical_position,
    output logic [1:0] limit_enable
);
    import adc_pkg::*;

    typedef enum logic [0:0] {ADC_IDLE, ADC_RUN} adc_state_t;

    adc_state_t state_ff;
    logic [ACC_W-1:0] acc_ff;
    logic [31:0] remain_ff;
    logic [31:0] pos_ff;
    logic dir_ff;
    logic pulse_ff;
    logic [ERR_W-1:0] err_ff;
    logic [1:0] limen_ff;
    logic soft_rst;
    logic start;
    logic start_dir;
    logic [31:0] start_cnt;
    logic [ERR_W-1:0] src;
    logic [ACC_W:0] acc_sum;
    logic tick;
    logic stop_cmd;
    logic fault_stop;

    function automatic logic [31:0] mag(input logic [31:0] v);
        return v[31] ? 32'(-v) : v;
    endfunction

    // [RULE_02] command reset code
    assign soft_rst = cmd.valid && cmd.code == CMD_RESET;
    assign stop_cmd = cmd.valid && cmd.code == CMD_STOP;

    // [RULE_13] drive command decode
    always_comb begin
        start = 1'b0;
        start_dir = 1'b0;
        start_cnt = 32'h0000_0000;
        if (cmd.valid) begin
            unique case (cmd.code)
                // [RULE_04] signed relative count
                CMD_REL_DRIVE: begin
                    start = 1'b1;
                    start_dir = cmd.data[31];
                    start_cnt = mag(cmd.data);
                end
                // [RULE_05] inverted direction
                CMD_CREL_DRIVE: begin
                    start = 1'b1;
                    start_dir = 1'b1;
                    start_cnt = cmd.data;
                end
                // [RULE_06] target minus position
                CMD_ABS_DRIVE: begin
                    start = 1'b1;
                    start_dir = $signed(cmd.data) < $signed(pos_ff);
                    start_cnt = mag(32'(cmd.data - pos_ff));
                end
                default: begin
                end
            endcase
        end
    end

    // [RULE_12] limits gated by enables
    assign src = {fault.estop, fault.alarm,
                  fault.neg_limit & limen_ff[LIMCFG_NEG_EN],
                  fault.pos_limit & limen_ff[LIMCFG_POS_EN]};
    assign fault_stop = |src;

    // [RULE_03] rate used as pulses per second directly
    assign acc_sum = {1'b0, acc_ff} + (ACC_W+1)'(speed_pps);
    assign tick = acc_sum >= (ACC_W+1)'(CLK_HZ);

    always_ff @(posedge clk) begin
        if (!external_reset_low || soft_rst) begin
            limen_ff <= LIMCFG_RESET;
        end else if (cmd.valid && cmd.code == CMD_LIMIT_CFG) begin
            limen_ff <= cmd.data[1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!external_reset_low || soft_rst) begin
            state_ff <= ADC_IDLE;
            remain_ff <= 32'h0000_0000;
            dir_ff <= 1'b0;
            acc_ff <= '0;
            pulse_ff <= 1'b0;
            pos_ff <= 32'h0000_0000;
        end else begin
            pulse_ff <= 1'b0;
            unique case (state_ff)
                ADC_IDLE: begin
                    acc_ff <= '0;
                    if (start && start_cnt != 32'h0000_0000) begin
                        state_ff <= ADC_RUN;
                        remain_ff <= start_cnt;
                        dir_ff <= start_dir;
                    end
                end
                ADC_RUN: begin
                    if (stop_cmd || fault_stop) begin
                        state_ff <= ADC_IDLE;
                    end else if (tick) begin
                        acc_ff <= ACC_W'(acc_sum - (ACC_W+1)'(CLK_HZ));
                        pulse_ff <= 1'b1;
                        pos_ff <= dir_ff ? pos_ff - 32'h1 : pos_ff + 32'h1;
                        remain_ff <= remain_ff - 32'h1;
                        if (remain_ff == 32'h1) begin
                            state_ff <= ADC_IDLE;
                        end
                    end else begin
                        acc_ff <= acc_sum[ACC_W-1:0];
                    end
                end
            endcase
        end
    end

    // [RULE_07] sticky during drive
    always_ff @(posedge clk) begin
        if (!external_reset_low || soft_rst) begin
            err_ff <= '0;
        end else if (start && state_ff == ADC_IDLE) begin
            // [RULE_08] source active at start is recorded
            err_ff <= src;
        end else if (state_ff == ADC_RUN) begin
            err_ff <= err_ff | src;
        end else if (cmd.valid && cmd.code == CMD_ERR_CLEAR) begin
            // [RULE_10] clear command; [RULE_09] idle sources ignored
            err_ff <= '0;
        end
    end

    assign pulse_out = pulse_ff;
    assign dir_minus = dir_ff;
    assign driving = state_ff == ADC_RUN;
    assign error_status_register = err_ff;
    assign logical_position = pos_ff;
    assign limit_enable = limen_ff;

    // Absolute drive bookkeeping, read only by the end-point check below.
    logic [31:0] abs_tgt_ff;
    logic abs_run_ff;

    always_ff @(posedge clk) begin
        if (!external_reset_low || soft_rst) begin
            abs_tgt_ff <= 32'h0000_0000;
            abs_run_ff <= 1'b0;
        end else if (start && state_ff == ADC_IDLE) begin
            abs_tgt_ff <= cmd.data;
            abs_run_ff <= cmd.code == CMD_ABS_DRIVE;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!external_reset_low);

    cmd_reset_a: assert property (soft_rst |=> !driving && err_ff == '0) // [RULE_02]
        else $error("command reset did not clear state");
    rel_dir_a: assert property (start && cmd.code == CMD_REL_DRIVE // [RULE_04]
        && !driving && start_cnt != 32'h0 |=> dir_minus == $past(cmd.data[31]))
        else $error("relative drive direction wrong");
    crel_dir_a: assert property (start && cmd.code == CMD_CREL_DRIVE // [RULE_05]
        && !driving && start_cnt != 32'h0 |=> dir_minus)
        else $error("counter relative drive not minus");
    abs_done_a: assert property ($fell(driving) && abs_run_ff // [RULE_06]
        && $past(!stop_cmd && !fault_stop) |-> logical_position == abs_tgt_ff)
        else $error("absolute drive ended off target");
    err_sticky_a: assert property (driving && src[0] |=> err_ff[0]) // [RULE_07]
        else $error("error bit not set during drive");
    err_start_a: assert property (start && !driving && src != '0 // [RULE_08]
        && !soft_rst |=> (err_ff & $past(src)) == $past(src))
        else $error("error active at start not recorded");
    idle_noerr_a: assert property (!driving && !start && !soft_rst // [RULE_09]
        && src != '0 |=> (err_ff & ~$past(err_ff)) == '0)
        else $error("error recorded while idle");
    err_clear_a: assert property (!driving && !start && !soft_rst // [RULE_10]
        && cmd.valid && cmd.code == CMD_ERR_CLEAR |=> err_ff == '0)
        else $error("status clear command failed");
    lim_off_a: assert property (limen_ff[0] == 1'b0 && driving // [RULE_12]
        && !fault.alarm && !fault.estop && !(fault.neg_limit && limen_ff[1])
        && !stop_cmd && !soft_rst && remain_ff > 32'h1 |=> driving)
        else $error("disabled limit stopped drive");

    run_cov: cover property (start ##1 driving ##[1:50] pulse_out);
    stop_cov: cover property (driving && fault_stop);
    rst_cov: cover property (soft_rst && driving);

endmodule // adc_axis_drive

// ===== adc_motor_model.sv
// Motor driver model: counts step pulses by direction into a signed position.
// Assumes pulse_out is a one-cycle pulse sampled on the rising edge of clk.
`timescale 1ns/1ps
module adc_motor_model (
    // Clock and reset
    input wire logic clk,
    input wire logic external_reset_low,
    // Step and direction from the axis
    input wire logic step,
    input wire logic minus,
    // Position the motor has really moved to
    output int pos
);
    always_ff @(posedge clk) begin
        if (!external_reset_low) begin
            pos <= 0;
        end else if (step) begin
            pos <= minus ? pos - 1 : pos + 1;
        end
    end
endmodule // adc_motor_model

// ===== axis_drive_command_and_error_status_bench.sv
// Self-checking bench for the axis drive block against an integer model.
// Assumes the motor model on the pulse outputs and a slowed clock parameter.
`timescale 1ns/1ps
module axis_drive_command_and_error_status_bench;
    import adc_pkg::*;
    logic clk, external_reset_low, pulse_out, dir_minus, driving;
    adc_cmd_t cmd;
    adc_fault_t fault;
    logic [31:0] speed_pps, lpos, seed;
    logic [3:0] err, merr;
    logic [1:0] lim;
    int mot_pos, miscompares, cmp_count, mpos, base;

    // The clock rate parameter is lowered so a pulse comes every few cycles.
    adc_axis_drive #(.CLK_HZ(1000)) i_adc_axis_drive (.clk(clk), .external_reset_low(external_reset_low),
        .cmd(cmd), .speed_pps(speed_pps), .fault(fault), .pulse_out(pulse_out),
        .dir_minus(dir_minus), .driving(driving), .error_status_register(err),
        .logical_position(lpos), .limit_enable(lim));
    adc_motor_model i_adc_motor_model (.clk(clk), .external_reset_low(external_reset_low), .step(pulse_out),
        .minus(dir_minus), .pos(mot_pos));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_state();
        chk({28'h0, err}, {28'h0, merr});
        chk(lpos, mpos);
        chk({31'h0, driving}, 32'h0);
    endtask
    task automatic send(input logic [15:0] code, input logic [31:0] data);
        @(posedge clk);
        cmd <= {1'b1, code, data};
        @(posedge clk);
        cmd <= '0;
    endtask
    task automatic setf(input adc_fault_t f);
        @(posedge clk);
        fault <= f;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (2) @(posedge clk);
        #1;
        while (driving !== 1'b0) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 4000) begin
                miscompares++;
                finish_test();
            end
        end
        // The last step reaches the motor one edge after driving falls.
        @(posedge clk);
        #1;
    endtask
    task automatic run(input logic [15:0] code, input logic [31:0] data);
        base = mot_pos;
        send(code, data);
        wait_idle();
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        int cnt, d, sg;
        logic [15:0] code;
        logic [31:0] data;
        external_reset_low = 1'b0;
        cmd = '0;
        speed_pps = 32'h0000_00C8;
        fault = '0;
        seed = 32'd20493;
        miscompares = 0;
        cmp_count = 0;
        mpos = 0;
        merr = 4'h0;
        repeat (10) @(posedge clk);
        external_reset_low <= 1'b1;
        @(posedge clk);
        #1;
        chk_state();
        chk({30'h0, lim}, 32'h3);
        for (int k = 0; k < 6; k++) begin
            cnt = 1 + int'(rnd() % 8);
            @(posedge clk);
            speed_pps <= 32'h0000_0064 + (rnd() % 32'h0000_0190);
            sg = (k % 2) ? -1 : 1;
            case (k % 3)
                0: begin code = CMD_REL_DRIVE; d = sg * cnt; data = d; end
                1: begin code = CMD_CREL_DRIVE; d = -cnt; data = cnt; end
                default: begin code = CMD_ABS_DRIVE; d = sg * cnt; data = mpos + d; end
            endcase
            run(code, data);
            chk(mot_pos - base, d);
            mpos += d;
            chk_state();
        end
        // An alarm in mid drive must stop it and stay recorded once released.
        base = mot_pos;
        send(CMD_REL_DRIVE, 32'h0000_0008);
        repeat (12) @(posedge clk);
        fault <= '{alarm: 1'b1, default: 1'b0};
        wait_idle();
        setf('0);
        repeat (3) @(posedge clk);
        #1;
        mpos += mot_pos - base;
        merr = 4'h4;
        chk({31'h0, mot_pos - base < 8}, 32'h1);
        chk_state();
        run(CMD_REL_DRIVE, 32'h0000_0002);
        mpos += 2;
        merr = 4'h0;
        chk_state();
        send(CMD_LIMIT_CFG, 32'h0);
        setf('{pos_limit: 1'b1, default: 1'b0});
        run(CMD_REL_DRIVE, 32'h0000_0003);
        mpos += 3;
        chk({30'h0, lim}, 32'h0);
        chk_state();
        send(CMD_LIMIT_CFG, 32'h3);
        run(CMD_REL_DRIVE, 32'h0000_0003);
        mpos += mot_pos - base;
        merr = 4'h1;
        chk_state();
        send(CMD_ERR_CLEAR, 32'h0);
        setf('{pos_limit: 1'b1, estop: 1'b1, default: 1'b0});
        repeat (3) @(posedge clk);
        #1;
        merr = 4'h0;
        chk_state();
        setf('0);
        send(CMD_LIMIT_CFG, 32'h0);
        send(CMD_RESET, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        mpos = 0;
        chk_state();
        chk({30'h0, lim}, 32'h3);
        finish_test();
    end
endmodule // axis_drive_command_and_error_status_bench
